//--- tick_params.svh
// Purpose: Register offsets, field positions, reset values and timing counts of the tick counter block
// Assumes: Included by the design modules
// Notes:   Definitions only
`ifndef TICK_PARAMS_SVH
`define TICK_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------------------
`define OFS_COUNT      4'h0
`define OFS_LIMIT      4'h1
`define OFS_CTRL       4'h2
`define OFS_STATUS     4'h3
`define OFS_CLEAR      4'h4
`define OFS_ENABLE     4'h5

// ----------------------------------------------------------------------------
// Control register fields: [7:6] source select, [3:0] divider select
// ----------------------------------------------------------------------------
`define CTRL_SRC_HI    7
`define CTRL_SRC_LO    6
`define CTRL_DIV_HI    3
`define CTRL_DIV_LO    0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_COUNT      8'h00
`define RST_LIMIT      8'h00
`define RST_SRC        2'h0
`define RST_DIV        4'h0

// ----------------------------------------------------------------------------
// Clock source strobe rates, derived from the 50 MHz system clock
// ----------------------------------------------------------------------------
`define SYS_CLK_HZ     50000000
`define LPO_HZ         1000
`define LPO_DIV        (`SYS_CLK_HZ / `LPO_HZ)

`endif

//--- tick_pkg.sv
// Purpose: Types shared by the tick counter block
// Assumes: tick_params.svh holds offsets, fields, reset values and clock rates
// Notes:   Types only
package tick_pkg;

  // Clock source choice
  typedef enum logic [1:0] {
    SRC_LPO = 2'h0,
    SRC_EXT = 2'h1,
    SRC_INT = 2'h2
  } tick_src_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Prescaler control
  typedef struct packed {
    logic [3:0] div_sel;
    logic       clear;
    logic       src_pulse;
  } presc_ctl_t;

endpackage

//--- tick_prescaler.sv
// Purpose: Prescaler producing one output tick per selected divide ratio
// Assumes: src_pulse is a one-cycle enable at the source rate
// Notes:   Selects 1..7 binary (8, 32, 64 .. 1024), 8..15 decimal (1, 2, 5, 10, 20, 50, 100, 1000)
`timescale 1ns/1ps
`include "tick_params.svh"
module tick_prescaler
  import tick_pkg::*;
(
  input  wire logic       SYS_CLK,   // System clock
  input  wire logic       RST,       // Asynchronous reset, active high
  input  wire presc_ctl_t CTL,       // Select, clear and source pulse
  output logic            TICK       // One-cycle prescaler output edge
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        tick_nxt;

  // Divide ratio for each selection, zero selection means off
  function automatic logic [15:0] ratio(input logic [3:0] sel);
    unique case (sel)
      4'h0: ratio = 16'h0000;
      4'h1: ratio = 16'h0008;
      4'h2: ratio = 16'h0020;
      4'h3: ratio = 16'h0040;
      4'h4: ratio = 16'h0080;
      4'h5: ratio = 16'h0100;
      4'h6: ratio = 16'h0200;
      4'h7: ratio = 16'h0400;
      4'h8: ratio = 16'h0001;
      4'h9: ratio = 16'h0002;
      4'hA: ratio = 16'h0005;
      4'hB: ratio = 16'h000A;
      4'hC: ratio = 16'h0014;
      4'hD: ratio = 16'h0032;
      4'hE: ratio = 16'h0064;
      4'hF: ratio = 16'h03E8;
    endcase
  endfunction

  // Count source pulses, emit a tick at the ratio
  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (CTL.clear || ratio(CTL.div_sel) == 16'h0000) begin
      cnt_nxt = 16'h0000;
    end else if (CTL.src_pulse) begin
      if (cnt_r + 16'h0001 >= ratio(CTL.div_sel)) begin
        cnt_nxt  = 16'h0000;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  // Registers
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cnt_r <= 16'h0000;
      TICK  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      TICK  <= tick_nxt;
    end
  end

endmodule

//--- tick_counter.sv
// Purpose: Periodic tick counter with compare limit, source select, prescaler and interrupt
// Assumes: External and internal reference clocks arrive as one-cycle enables on SYS_CLK
// Notes:   Low-power oscillator strobe is made here by a divider of the system clock
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "tick_params.svh"

// Function
// - Tick count is readable; writes to it are ignored.
// - Compare limit is an 8-bit read/write register.
// - Count equal to limit returns count to zero and sets match flag.
// - Limit zero sets match flag on every prescaler output edge.
// - Writing the limit clears prescaler and counter.
// - Writing a different source clears prescaler and counter.
// - Writing a different divider selection clears the count.
// - Reset stops counter at zero, limit zero, prescaler off.
// - Reset selects the low-power oscillator as source.
// - Prescaler off while selection zero; nonzero selection starts counting.
// - Three selectable sources: low-power, external and internal reference.
// - Divider offers binary and decimal ratio sets.
// - Enabled match flag requests an interrupt.
module tick_counter
  import tick_pkg::*;
(
  input  wire logic       SYS_CLK,    // System clock, 50 MHz
  input  wire logic       RST,        // Asynchronous reset, active high
  input  wire logic [3:0] ADDR,       // Register index
  input  wire logic [7:0] WDATA,      // Write data
  input  wire logic       WR,         // Write strobe
  input  wire logic       RD,         // Read strobe
  output logic      [7:0] RDATA,      // Read data, cycle after RD
  input  wire logic       EXT_REF_EN, // External reference clock edge enable
  input  wire logic       INT_REF_EN, // Internal reference clock edge enable
  output logic            IRQ         // Level interrupt
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg_req_t    req;
  presc_ctl_t  pctl;
  logic        presc_tick;

  logic [7:0]  count_r,  count_nxt;
  logic [7:0]  limit_r,  limit_nxt;
  tick_src_t   src_r,    src_nxt;
  logic [3:0]  div_r,    div_nxt;
  logic        flag_r,   flag_nxt;
  logic        ien_r,    ien_nxt;
  logic [7:0]  rdata_nxt;
  logic [15:0] lpo_cnt_r, lpo_cnt_nxt;
  logic        lpo_pulse;
  logic        presc_clr;
  logic        count_clr;
  logic        match_evt;

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // Write decode helper
  function automatic logic hit(input reg_req_t r, input logic [3:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  // --------------------------------------------------------------------------
  // Low-power oscillator strobe
  // --------------------------------------------------------------------------
  // Divide system clock down to a 1 kHz enable
  always_comb begin
    lpo_pulse   = (lpo_cnt_r == 16'(`LPO_DIV - 1));
    lpo_cnt_nxt = lpo_pulse ? 16'h0000 : lpo_cnt_r + 16'h0001;
  end

  // --------------------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------------------
  // Source mux and clear conditions
  always_comb begin
    presc_clr = hit(req, `OFS_LIMIT)
              || (hit(req, `OFS_CTRL)
                  && req.wdata[`CTRL_SRC_HI:`CTRL_SRC_LO] != 2'h3   // Refused code keeps source and count
                  && req.wdata[`CTRL_SRC_HI:`CTRL_SRC_LO] != src_r);
    pctl.clear   = presc_clr;
    pctl.div_sel = div_r;
    unique case (src_r)
      SRC_EXT: pctl.src_pulse = EXT_REF_EN;
      SRC_INT: pctl.src_pulse = INT_REF_EN;
      default: pctl.src_pulse = lpo_pulse;
    endcase
  end

  // Binary and decimal divider
  tick_prescaler u_presc (
    .SYS_CLK (SYS_CLK),
    .RST     (RST),
    .CTL     (pctl),
    .TICK    (presc_tick)
  );

  // --------------------------------------------------------------------------
  // Counter, registers and flag
  // --------------------------------------------------------------------------
  // Next-state logic for counter and software registers
  always_comb begin
    count_nxt = count_r;
    limit_nxt = limit_r;
    src_nxt   = src_r;
    div_nxt   = div_r;
    flag_nxt  = flag_r;
    ien_nxt   = ien_r;
    match_evt = 1'b0;
    count_clr = presc_clr
              || (hit(req, `OFS_CTRL) && req.wdata[`CTRL_DIV_HI:`CTRL_DIV_LO] != div_r);

    if (hit(req, `OFS_LIMIT)) begin
      limit_nxt = req.wdata;
    end
    if (hit(req, `OFS_CTRL)) begin
      src_nxt = tick_src_t'(req.wdata[`CTRL_SRC_HI:`CTRL_SRC_LO]);
      if (req.wdata[`CTRL_SRC_HI:`CTRL_SRC_LO] == 2'h3) begin
        src_nxt = src_r;
      end
      div_nxt = req.wdata[`CTRL_DIV_HI:`CTRL_DIV_LO];
    end
    if (hit(req, `OFS_ENABLE)) begin
      ien_nxt = req.wdata[0];
    end
    // Clear first, so a match in the same cycle still sets the flag
    if (hit(req, `OFS_CLEAR) && req.wdata[0]) begin
      flag_nxt = 1'b0;
    end

    if (count_clr) begin
      count_nxt = `RST_COUNT;
    end else if (presc_tick) begin
      if (count_r == limit_r) begin
        count_nxt = 8'h00;
        match_evt = 1'b1;
      end else begin
        count_nxt = count_r + 8'h01;
      end
    end
    if (match_evt) begin
      flag_nxt = 1'b1;
    end
  end

  // Read mux; count has no write path
  always_comb begin
    rdata_nxt = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `OFS_COUNT:  rdata_nxt = count_r;
        `OFS_LIMIT:  rdata_nxt = limit_r;
        `OFS_CTRL:   rdata_nxt = {src_r, 2'h0, div_r};
        `OFS_STATUS: rdata_nxt = {7'h00, flag_r};
        `OFS_ENABLE: rdata_nxt = {7'h00, ien_r};
        default:     rdata_nxt = 8'h00;
      endcase
    end
  end

  // Registers
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      count_r   <= `RST_COUNT;
      limit_r   <= `RST_LIMIT;
      src_r     <= SRC_LPO;
      div_r     <= `RST_DIV;
      flag_r    <= 1'b0;
      ien_r     <= 1'b0;
      RDATA     <= 8'h00;
      lpo_cnt_r <= 16'h0000;
    end else begin
      count_r   <= count_nxt;
      limit_r   <= limit_nxt;
      src_r     <= src_nxt;
      div_r     <= div_nxt;
      flag_r    <= flag_nxt;
      ien_r     <= ien_nxt;
      RDATA     <= rdata_nxt;
      lpo_cnt_r <= lpo_cnt_nxt;
    end
  end

  // Level interrupt from enabled flag
  assign IRQ = flag_r & ien_r;

endmodule

//--- tick_counter_asserts.sv
// Purpose: Port-level assertions for the tick counter
// Assumes: One clock domain, reset active high
// Notes:   Reference enables are idle around checked accesses
`timescale 1ns/1ps
module tick_counter_asserts (
  input wire logic       SYS_CLK,    // System clock
  input wire logic       RST,        // Reset
  input wire logic [3:0] ADDR,       // Register index
  input wire logic [7:0] WDATA,      // Write data
  input wire logic       WR,         // Write strobe
  input wire logic       RD,         // Read strobe
  input wire logic [7:0] RDATA,      // Read data
  input wire logic       EXT_REF_EN, // External enable
  input wire logic       INT_REF_EN, // Internal enable
  input wire logic       IRQ         // Interrupt
);
  // ----
  // Bus and interrupt checks
  // ----
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  chk_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data not zero outside a read");
  chk_reset_quiet: assert property ($fell(RST) |-> !IRQ && RDATA == 8'h00)
    else $error("outputs busy after reset");
  chk_limit_readback: assert property (WR && ADDR == 4'h1 ##1 RD && ADDR == 4'h1
    |=> RDATA == $past(WDATA, 2))
    else $error("limit read back differs");
  chk_limit_clears: assert property (WR && ADDR == 4'h1 ##1 RD && ADDR == 4'h0 |=> RDATA == 8'h00)
    else $error("count not cleared by limit write");
  chk_count_ignored: assert property (RD && ADDR == 4'h0 ##1 WR && ADDR == 4'h0 ##1 RD && ADDR == 4'h0
    |=> RDATA == $past(RDATA, 2))
    else $error("count changed by a write");
  chk_irq_clear: assert property (WR && ADDR == 4'h4 && WDATA[0] && !$past(EXT_REF_EN)
    && !$past(INT_REF_EN) |=> !IRQ)
    else $error("interrupt stays after clear");
  chk_irq_mask: assert property (WR && ADDR == 4'h5 && !WDATA[0] |=> !IRQ)
    else $error("interrupt high while disabled");
  chk_irq_status: assert property (RD && ADDR == 4'h3 && IRQ |=> RDATA[0])
    else $error("interrupt without status flag");

  cover property ($rose(IRQ));
  cover property (WR && ADDR == 4'h4 && IRQ);
  cover property (RD && ADDR == 4'h3 && IRQ);
endmodule

//--- test_periodic_tick_counter.sv
// Purpose: Self-checking bench for the tick counter
// Assumes: Reference clocks arrive as one-cycle enables
// Notes:   A register model predicts every read and the interrupt
`timescale 1ns/1ps
module test_periodic_tick_counter;
  logic       SYS_CLK, RST, WR, RD, EXT_REF_EN, INT_REF_EN, IRQ;
  logic [3:0] ADDR;
  logic [7:0] WDATA, RDATA;
  int         mismatches, samples_checked, cnt, lim, flg, ien, src, dsel, pc, j, k;
  int         exp_q[$];
  int         rat[16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 5, 10, 20, 50, 100, 1000};

  tick_counter i_tick_counter (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .EXT_REF_EN(EXT_REF_EN), .INT_REF_EN(INT_REF_EN), .IRQ(IRQ));

  // ----
  // Helpers
  // ----
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One bus cycle, all inputs changed together
  task automatic step(input logic w, r, input logic [3:0] a, input logic [7:0] d, input logic e, i);
    {WR, RD, ADDR, WDATA, EXT_REF_EN, INT_REF_EN} <= {w, r, a, d, e, i};
    @(posedge SYS_CLK);
  endtask

  // Register write, mirrored in the model
  task automatic wr(input int a, input int d);
    step(1'b1, 1'b0, 4'(a), 8'(d), 1'b0, 1'b0);
    // Limit write or new source restarts prescaler and count; a new divider clears only the count
    if (a == 1 || (a == 2 && (d >> 6) != 3 && (d >> 6) != src)) begin
      cnt = 0;
      pc = 0;
    end
    if (a == 2 && (d & 15) != dsel) cnt = 0;
    if (a == 1) lim = d & 255;
    if (a == 2 && (d >> 6) != 3) src = d >> 6;
    if (a == 2) dsel = d & 15;
    if (dsel == 0) pc = 0;
    if (a == 4 && d[0]) flg = 0;
    if (a == 5) ien = d & 1;
  endtask

  // Register read; the answer is queued for the monitor
  task automatic rd(input int a);
    exp_q.push_back(a == 0 ? cnt : a == 1 ? lim : a == 2 ? src * 64 + dsel : a == 3 ? flg : a == 5 ? ien : 0);
    step(1'b0, 1'b1, 4'(a), 8'h00, 1'b0, 1'b0);
  endtask

  // Source pulses; the unselected enable toggles at random
  task automatic pulse(input int n);
    repeat (n) begin
      k = $urandom % 2;
      step(1'b0, 1'b0, 4'h0, 8'h00, 1'(src == 1 || k), 1'(src == 2 || k == 0));
      pc += (src != 0 && dsel != 0);
      // Prescaler count survives a divider change, so a smaller ratio ends it on the next source pulse
      if (pc >= rat[dsel] && pc > 0) begin
        pc = 0;
        flg |= (cnt == lim);
        cnt = (cnt == lim) ? 0 : cnt + 1;
      end
      repeat (3) step(1'b0, 1'b0, 4'h0, 8'h00, 1'b0, 1'b0);
    end
  endtask

  // Interrupt compared just after the edge, without holding up the stimulus
  task automatic irq_is();
    int e;
    e = flg & ien;
    fork
      begin
        #1;
        check("irq", {7'h00, IRQ}, 8'(e));
      end
    join_none
  endtask

  // Read answers compared in the cycle after the strobe
  initial forever begin
    @(posedge SYS_CLK);
    if (RD === 1'b1) begin
      #1;
      check("rdata", RDATA, 8'(exp_q.pop_front()));
    end
  end

  // Clock
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  // Watchdog
  initial begin
    #1000000;
    mismatches++;
    wrap_up();
  end

  // Main sequence
  initial begin
    {WR, RD, ADDR, WDATA, EXT_REF_EN, INT_REF_EN} = '0;
    RST = 1'b1;
    k = $urandom(32'h5681);
    repeat (16) @(posedge SYS_CLK);
    RST <= 1'b0;
    for (j = 0; j < 16; j++) rd(j);
    irq_is();
    rd(0);
    wr(0, $urandom);
    rd(0);
    wr(1, $urandom);
    rd(1);
    wr(2, 8'h80);
    pulse(5);
    rd(0);
    wr(2, 8'h88);
    wr(1, $urandom % 8 + 2);
    rd(0);
    wr(5, 1);
    repeat (8) begin
      pulse($urandom % 12 + 1);
      rd(0);
      rd(3);
      irq_is();
      if ($urandom % 2) wr(4, 1);
    end
    pulse(lim + 1);
    wr(5, 0);
    irq_is();
    wr(5, 1);
    irq_is();
    wr(2, 8'h48);
    rd(0);
    pulse(3);
    rd(0);
    wr(2, 8'h49);
    rd(0);
    wr(2, 8'hC9);
    rd(2);
    for (j = 1; j < 16; j++) begin
      wr(2, 8'h40 + j);
      wr(1, 0);
      wr(4, 1);
      pulse(rat[j] - 1);
      rd(3);
      pulse(1);
      rd(3);
    end
    // Second reset in mid-run, once the last read answer has been taken
    step(1'b0, 1'b0, 4'h0, 8'h00, 1'b0, 1'b0);
    RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    cnt = 0;
    lim = 0;
    flg = 0;
    ien = 0;
    src = 0;
    dsel = 0;
    pc = 0;
    for (j = 0; j < 6; j++) rd(j);
    irq_is();
    // Let the last read answer and interrupt check land before the verdict
    step(1'b0, 1'b0, 4'h0, 8'h00, 1'b0, 1'b0);
    wrap_up();
  end
endmodule

bind tick_counter tick_counter_asserts i_tick_counter_asserts (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EXT_REF_EN(EXT_REF_EN), .INT_REF_EN(INT_REF_EN), .IRQ(IRQ));
